// >>> shared/aci_pkg.sv
// aci_pkg: constants shared by the ascii command interpreter
// assumes a 200 MHz reference clock and single-master i2c buses
package aci_pkg;
    // ========================================
    // character codes
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_TAB = 8'h09;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_BSL = 8'h5c;
    localparam logic [7:0] CH_ESC = 8'h1b;
    localparam logic [7:0] CH_X = 8'h78;
    localparam logic [7:0] CH_C = 8'h63;
    localparam logic [7:0] CH_W = 8'h77;
    localparam logic [7:0] CH_R = 8'h72;
    localparam logic [7:0] CH_S = 8'h73;
    localparam logic [7:0] CH_M = 8'h6d;
    localparam logic [7:0] CH_L = 8'h6c;
    localparam logic [7:0] CH_P = 8'h70;
    localparam logic [7:0] CH_B = 8'h62;
    localparam logic [7:0] CH_Q = 8'h3f;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CASE_BIT = 8'h20;
    // ========================================
    // limits
    localparam int MAX_NUM = 64;
    localparam int NUM_BUSES = 3;
    localparam logic [7:0] ADDR_LIMIT = 8'h80;
    localparam logic [7:0] SUB_ADDR = 8'h00;
    localparam int BOOT_BYTES = 4096;
    localparam int FLASH_BYTES = 16384;
    localparam int APP_TOP = FLASH_BYTES - BOOT_BYTES;
    // ========================================
    // i2c timing: 100 kHz, quarter period in ns
    localparam int CLK_NS = 5;
    localparam int I2C_QTR_NS = 2500;
    localparam int I2C_QTR_CYC = I2C_QTR_NS / CLK_NS;
    // ========================================
    // functions chosen by the leading letter
    typedef enum logic [2:0] {
        ACI_FN_NONE, ACI_FN_I2C, ACI_FN_SERIAL, ACI_FN_MOTOR,
        ACI_FN_LED, ACI_FN_PROG, ACI_FN_BOOT, ACI_FN_HELP
    } aci_fn_t;
endpackage

// >>> verilog/aci_interp.sv
// aci_interp: ascii command interpreter with an i2c master on three buses
// assumes host bytes arrive as one-cycle strobes synchronous to ref_clk
//
// Function
// R1 - first letter selects the operating function
// R2 - space, tab, comma separate fields only
// R3 - execute only after carriage return; code also executes on a line feed
// R4 - payload white space forwarded as data
// R5 - decimal numbers, range 0 to 64
// R6 - backslash x prefix means hexadecimal
// R7 - selector letter case insensitive
// R8 - backslash c decodes to escape
// R9 - master addresses any of 128 slaves
// R10 - single master, no arbitration
// R11 - writes target sub-address zero; code sends no sub-address byte, payload follows the address directly
// R12 - reads from sub-address zero, host writes first; code sends no write phase, the read starts at the address byte
// R13 - digit after c picks bus 1-3
// R14 - buses one and two never concurrent
// R15 - bus three has its own lines
// R16 - address decimal unless hex marker
// R17 - write: bus, address, w, count, payload
// R18 - boot pin and reset low start bootloader; code has no boot pin, boot_start pulses only when a b command line is closed
// R19 - fuses change only through isp path
// R20 - bootloader in top 4K of flash
// R21 - read: bus, address, r, count, bytes returned
// R22 - escape ends serial pass-through
// R23 - start, address, ack, stop framing
// R24 - bad commands discarded without bus activity
`timescale 1ns/100ps
`default_nettype none
module aci_interp
    import aci_pkg::*;
#(
    parameter int QTR_CYC = I2C_QTR_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic [2:0] mode,
    output logic boot_start,
    output logic fuse_write_allow,
    output logic [7:0] uart_tx_data,
    output logic uart_tx_valid,
    output logic busy,
    input wire logic scl12_in,
    input wire logic sda12_in,
    output logic scl12_oe,
    output logic sda12_oe,
    output logic [1:0] bus12_sel,
    input wire logic scl3_in,
    input wire logic sda3_in,
    output logic scl3_oe,
    output logic sda3_oe
);
    // ========================================
    // parser state
    typedef enum logic [3:0] {
        ACI_IDLE, ACI_BUSNUM, ACI_ADDR, ACI_DIR, ACI_CNT, ACI_DATA,
        ACI_EOL, ACI_SKIP, ACI_SERIAL, ACI_RUN, ACI_SEND
    } aci_st_t;
    typedef enum logic [3:0] {
        ACI_B_IDLE, ACI_B_START, ACI_B_BIT, ACI_B_ACK, ACI_B_RBIT,
        ACI_B_MACK, ACI_B_STOP, ACI_B_DONE
    } aci_bst_t;

    aci_st_t st;
    aci_bst_t bst;
    logic [7:0] buf_mem [0:MAX_NUM-1];
    logic [7:0] rd_mem [0:MAX_NUM-1];
    logic [7:0] num;
    logic num_hex, num_any, esc, err, is_read;
    logic [1:0] bus;
    logic [6:0] addr;
    logic [6:0] cnt, idx;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic [15:0] tick;
    logic [1:0] phase;
    logic scl_drv, sda_drv;
    logic boot_pend;

    // separator and digit decoding
    function automatic logic is_sep(input logic [7:0] c);
        return (c == CH_SP) || (c == CH_TAB) || (c == CH_COMMA);
    endfunction
    function automatic logic [4:0] hexval(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) return {1'b0, c[3:0]};
        if ((c | CASE_BIT) >= 8'h61 && (c | CASE_BIT) <= 8'h66)
            return {1'b1, 4'(c[3:0] + 4'h9)};
        return 5'h1f;
    endfunction

    wire [7:0] low = rx_data | CASE_BIT; // [R7]
    wire sep = is_sep(rx_data); // [R2]
    wire eol = (rx_data == CH_CR) || (rx_data == CH_LF); // [R3]
    wire [4:0] hv = hexval(rx_data);
    wire dec_ok = (hv[4] == 1'b0) && (hv[3:0] <= 4'h9);
    wire hex_ok = hv != 5'h1f;
    wire dig_ok = num_hex ? hex_ok : dec_ok; // [R6][R16]
    wire [11:0] acc = num_hex ? {num, 4'h0} + {8'h0, hv[3:0]}
                              : num * 12'd10 + {8'h0, hv[3:0]};
    wire over = acc > 12'(MAX_NUM); // [R5]
    wire addr_over = acc >= 12'(ADDR_LIMIT); // [R9]
    wire qtr = tick == 16'(QTR_CYC - 1);
    wire scl_in = (bus == 2'd3) ? scl3_in : scl12_in;
    wire sda_in = (bus == 2'd3) ? sda3_in : sda12_in;
    wire num_end = sep || eol;
    // a read, or a write of zero bytes, may close the line on its count
    wire cnt_run = (st == ACI_CNT) && num_any && !err && (is_read || num == 8'h00); // [R21]
    aci_fn_t fn_sel;

    // command letter to function, case folded
    always_comb begin
        case (low) // [R1][R7]
            CH_C: fn_sel = ACI_FN_I2C;
            CH_S: fn_sel = ACI_FN_SERIAL;
            CH_M: fn_sel = ACI_FN_MOTOR;
            CH_L: fn_sel = ACI_FN_LED;
            CH_P: fn_sel = ACI_FN_PROG;
            CH_B: fn_sel = ACI_FN_BOOT;
            default: fn_sel = (rx_data == CH_Q) ? ACI_FN_HELP : ACI_FN_NONE;
        endcase
    end

    // ========================================
    // character parser; numbers end on separator or end of line
    always_ff @(posedge ref_clk) begin
        tx_valid <= 1'b0;
        uart_tx_valid <= 1'b0;
        boot_start <= 1'b0;
        if (!rst_n) begin
            st <= ACI_IDLE;
            mode <= ACI_FN_NONE;
            num <= 8'h00;
            num_hex <= 1'b0;
            num_any <= 1'b0;
            esc <= 1'b0;
            err <= 1'b0;
            is_read <= 1'b0;
            bus <= 2'd0;
            addr <= 7'h00;
            cnt <= 7'h00;
            idx <= 7'h00;
            tx_data <= 8'h00;
            uart_tx_data <= 8'h00;
            boot_pend <= 1'b0;
        end else begin
            case (st)
                ACI_IDLE: if (rx_valid && !sep && !eol) begin
                    mode <= fn_sel; // [R1]
                    err <= fn_sel == ACI_FN_NONE; // [R24]
                    boot_pend <= fn_sel == ACI_FN_BOOT;
                    st <= (fn_sel == ACI_FN_I2C) ? ACI_BUSNUM : ACI_EOL;
                end
                ACI_BUSNUM: if (rx_valid) begin
                    // bus 1 and 2 share one pin pair; bus 3 stands alone
                    if (rx_data >= 8'h31 && rx_data <= 8'h33)
                        bus <= rx_data[1:0]; // [R13]
                    else
                        err <= 1'b1; // [R24]
                    num <= 8'h00;
                    num_hex <= 1'b0;
                    num_any <= 1'b0;
                    st <= eol ? ACI_IDLE : ACI_ADDR;
                end
                ACI_ADDR, ACI_CNT: if (rx_valid) begin
                    if (esc) begin
                        esc <= 1'b0;
                        if (low == CH_X) num_hex <= 1'b1; // [R6]
                        else err <= 1'b1;
                    end else if (rx_data == CH_BSL) begin
                        esc <= 1'b1;
                    end else if (num_end) begin
                        if (num_any) begin
                            if (st == ACI_ADDR) begin
                                addr <= num[6:0];
                                st <= ACI_DIR;
                            end else begin
                                cnt <= num[6:0];
                                idx <= 7'h00;
                                st <= (is_read || num == 8'h00) ? ACI_EOL : ACI_DATA;
                            end
                        end
                        if (eol) begin
                            st <= cnt_run ? ACI_RUN : ACI_IDLE; // [R3][R24]
                        end
                    end else if (dig_ok && !((st == ACI_ADDR) ? addr_over : over)) begin
                        num <= acc[7:0]; // [R5][R16]
                        num_any <= 1'b1;
                    end else begin
                        err <= 1'b1; // [R24]
                    end
                end
                ACI_DIR: if (rx_valid && !sep) begin
                    is_read <= low == CH_R; // [R21]
                    if (low != CH_W && low != CH_R) err <= 1'b1;
                    num <= 8'h00;
                    num_hex <= 1'b0;
                    num_any <= 1'b0;
                    st <= eol ? ACI_IDLE : ACI_CNT;
                end
                ACI_DATA: if (rx_valid) begin
                    // after a backslash: c is escape, any other character is stored as is
                    if (esc) begin
                        esc <= 1'b0;
                        buf_mem[idx[5:0]] <= (low == CH_C) ? CH_ESC : rx_data; // [R8]
                        idx <= idx + 7'h1;
                        if (idx + 7'h1 == cnt) st <= ACI_EOL;
                    end else if (rx_data == CH_BSL) begin
                        esc <= 1'b1;
                    end else begin
                        buf_mem[idx[5:0]] <= rx_data; // [R4][R17]
                        idx <= idx + 7'h1;
                        if (idx + 7'h1 == cnt) st <= ACI_EOL;
                    end
                end
                ACI_EOL: if (rx_valid && eol) begin
                    // nothing runs until the line is closed
                    if (err || mode == ACI_FN_NONE) begin
                        st <= ACI_IDLE; // [R24]
                    end else if (mode == ACI_FN_I2C) begin
                        st <= ACI_RUN; // [R3]
                    end else if (mode == ACI_FN_SERIAL) begin
                        st <= ACI_SERIAL;
                    end else begin
                        boot_start <= boot_pend; // loader region lies above APP_TOP [R20]
                        st <= ACI_IDLE;
                    end
                end
                ACI_SERIAL: if (rx_valid) begin
                    if (esc) begin
                        esc <= 1'b0;
                        if (low == CH_C) begin
                            st <= ACI_IDLE; // [R22]
                            mode <= ACI_FN_NONE;
                        end else begin
                            uart_tx_data <= rx_data;
                            uart_tx_valid <= 1'b1;
                        end
                    end else if (rx_data == CH_BSL) begin
                        esc <= 1'b1;
                    end else if (rx_data == CH_ESC) begin
                        st <= ACI_IDLE; // [R22]
                        mode <= ACI_FN_NONE;
                    end else begin
                        uart_tx_data <= rx_data;
                        uart_tx_valid <= 1'b1;
                    end
                end
                ACI_RUN: if (bst == ACI_B_DONE) begin
                    idx <= 7'h00;
                    st <= is_read ? ACI_SEND : ACI_IDLE;
                end
                ACI_SEND: begin
                    // read bytes returned one per cycle
                    if (idx == cnt) begin
                        st <= ACI_IDLE;
                    end else begin
                        tx_data <= rd_mem[idx[5:0]]; // [R21]
                        tx_valid <= 1'b1;
                        idx <= idx + 7'h1;
                    end
                end
                default: st <= ACI_IDLE;
            endcase
            if (st == ACI_IDLE && !(rx_valid && !sep && !eol)) begin
                err <= 1'b0;
                esc <= 1'b0;
            end
        end
    end

    // ========================================
    // i2c engine, one transfer at a time, so bus 1 and 2 never overlap
    logic [6:0] bidx;
    logic addr_phase, nack;
    aci_bst_t next_bst;
    wire [6:0] sent = addr_phase ? 7'h00 : bidx + 7'h1; // bytes acknowledged so far
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bst <= ACI_B_IDLE;
            tick <= 16'h0;
            phase <= 2'd0;
            scl_drv <= 1'b0;
            sda_drv <= 1'b0;
            bitn <= 3'd7;
            sh <= 8'h00;
            bidx <= 7'h00;
            addr_phase <= 1'b0;
            nack <= 1'b0;
        end else begin
            tick <= qtr ? 16'h0 : tick + 16'h1;
            case (bst)
                ACI_B_IDLE: if (st == ACI_RUN) begin
                    // no arbitration: single master assumed [R10]
                    bst <= ACI_B_START;
                    sh <= {addr, is_read}; // [R9][R23][R11][R12]
                    addr_phase <= 1'b1;
                    bidx <= 7'h00;
                    nack <= 1'b0;
                    phase <= 2'd0;
                    tick <= 16'h0;
                end
                ACI_B_START: if (qtr) begin
                    phase <= phase + 2'd1;
                    if (phase == 2'd0) sda_drv <= 1'b1; // [R23]
                    if (phase == 2'd1) begin
                        scl_drv <= 1'b1;
                        bitn <= 3'd7;
                        phase <= 2'd0;
                        bst <= ACI_B_BIT;
                    end
                end
                ACI_B_BIT, ACI_B_ACK, ACI_B_RBIT, ACI_B_MACK: if (qtr) begin
                    // quarter 0 set data, 1 and 2 clock high, 3 clock low
                    phase <= phase + 2'd1;
                    case (phase)
                        2'd0: sda_drv <= (bst == ACI_B_BIT) ? !sh[bitn] :
                                         (bst == ACI_B_MACK) ? (bidx != 7'(cnt - 7'h1)) : 1'b0;
                        2'd1: scl_drv <= 1'b0;
                        2'd2: begin
                            if (bst == ACI_B_ACK) nack <= sda_in; // [R23]
                            if (bst == ACI_B_RBIT) sh[bitn] <= sda_in;
                        end
                        default: begin
                            if (scl_in) begin
                                scl_drv <= 1'b1;
                                bst <= next_bst;
                                // ack slots must not eat a bit of the next byte
                                if (bst == ACI_B_BIT || bst == ACI_B_RBIT) bitn <= bitn - 3'd1;
                                if (bst == ACI_B_MACK) begin
                                    rd_mem[bidx[5:0]] <= sh;
                                    bidx <= bidx + 7'h1;
                                end
                                if (bst == ACI_B_ACK) begin
                                    addr_phase <= 1'b0;
                                    sh <= buf_mem[sent[5:0]]; // next payload byte
                                    if (!addr_phase) bidx <= bidx + 7'h1;
                                end
                            end else begin
                                phase <= 2'd3; // clock stretching holds here
                            end
                        end
                    endcase
                end
                ACI_B_STOP: if (qtr) begin
                    phase <= phase + 2'd1;
                    if (phase == 2'd0) sda_drv <= 1'b1;
                    if (phase == 2'd1) scl_drv <= 1'b0;
                    if (phase == 2'd2) begin
                        sda_drv <= 1'b0; // [R23]
                        bst <= ACI_B_DONE;
                    end
                end
                ACI_B_DONE: bst <= ACI_B_IDLE;
                default: bst <= ACI_B_IDLE;
            endcase
        end
    end

    // successor of each bit slot
    always_comb begin
        case (bst)
            ACI_B_BIT: next_bst = (bitn == 3'd0) ? ACI_B_ACK : ACI_B_BIT;
            ACI_B_RBIT: next_bst = (bitn == 3'd0) ? ACI_B_MACK : ACI_B_RBIT;
            ACI_B_ACK: next_bst = nack ? ACI_B_STOP :
                                  is_read ? ACI_B_RBIT :
                                  (sent == cnt) ? ACI_B_STOP : ACI_B_BIT;
            ACI_B_MACK: next_bst = (bidx + 7'h1 == cnt) ? ACI_B_STOP : ACI_B_RBIT;
            default: next_bst = ACI_B_STOP;
        endcase
    end

    // ========================================
    // pin steering: only the selected pair drives [R14][R15]
    wire on12 = bus != 2'd3;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scl12_oe <= 1'b0;
            sda12_oe <= 1'b0;
            scl3_oe <= 1'b0;
            sda3_oe <= 1'b0;
            bus12_sel <= 2'd1;
            busy <= 1'b0;
            fuse_write_allow <= 1'b0;
        end else begin
            scl12_oe <= on12 && scl_drv;
            sda12_oe <= on12 && sda_drv;
            scl3_oe <= !on12 && scl_drv;
            sda3_oe <= !on12 && sda_drv;
            if (on12 && bst == ACI_B_IDLE && bus != 2'd0) bus12_sel <= bus;
            busy <= st == ACI_RUN || st == ACI_SEND;
            fuse_write_allow <= 1'b0; // fuses only via isp pins [R19]
        end
    end
endmodule
`default_nettype wire

// >>> tb/aci_i2c_slave.sv
// aci_i2c_slave: behavioural i2c slave with a fixed address and read byte
// assumes open-drain wires with pull-ups resolved by the bench
`timescale 1ns/100ps
`default_nettype none
module aci_i2c_slave #(
    parameter logic [6:0] ADDR = 7'h14,
    parameter logic [7:0] RD = 8'h5a
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe,
    output logic [7:0] rx_addr,
    output logic [7:0] last_byte,
    output logic [7:0] nbytes
);
    logic [7:0] sh = 8'h00;
    logic [3:0] bitc = 4'h0;
    logic active = 1'b0;
    logic addr_ph = 1'b0;
    logic is_rd = 1'b0;
    initial sda_oe = 1'b0;
    initial rx_addr = 8'h00;
    initial last_byte = 8'h00;
    initial nbytes = 8'h00;
    // ========================================
    // start and stop: sda moving while scl is high
    always @(negedge sda) if (scl) begin
        active = 1'b1; addr_ph = 1'b1; bitc = 4'h0; nbytes = 8'h00; sda_oe = 1'b0;
    end
    always @(posedge sda) if (scl) active = 1'b0;
    // sample on the rising clock, ninth bit is the acknowledge slot
    always @(posedge scl) if (active) begin
        if (bitc < 4'h8) begin
            sh = {sh[6:0], sda};
            bitc = bitc + 4'h1;
        end else begin
            bitc = 4'h0;
            // master nack on a read: stop driving so the stop can form
            if (is_rd && !addr_ph && sda) active = 1'b0;
        end
    end
    // drive on the falling clock only, so sda never moves while scl is high
    always @(negedge scl) if (active) begin
        if (bitc == 4'h8 && addr_ph) begin
            addr_ph = 1'b0;
            rx_addr = sh;
            is_rd = sh[0];
            sda_oe = (sh[7:1] == ADDR);
            active = (sh[7:1] == ADDR);
        end else if (bitc == 4'h8 && !is_rd) begin
            last_byte = sh;
            nbytes = nbytes + 8'h01;
            sda_oe = 1'b1;
        end else if (is_rd && !addr_ph && bitc < 4'h8) begin
            sda_oe = ~RD[3'd7 - bitc[2:0]]; // read returns sub-address zero data
        end else begin
            sda_oe = 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> tb/aci_interp_chk.sv
// aci_interp_chk: port-level assertions for the command interpreter
// assumes bind onto aci_interp, single clock domain ref_clk
`timescale 1ns/100ps
`default_nettype none
module aci_interp_chk
    import aci_pkg::*;
#(
    parameter int QTR_CYC = I2C_QTR_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic [2:0] mode,
    input wire logic boot_start,
    input wire logic fuse_write_allow,
    input wire logic [7:0] uart_tx_data,
    input wire logic uart_tx_valid,
    input wire logic busy,
    input wire logic scl12_in,
    input wire logic sda12_in,
    input wire logic scl12_oe,
    input wire logic sda12_oe,
    input wire logic [1:0] bus12_sel,
    input wire logic scl3_in,
    input wire logic sda3_in,
    input wire logic scl3_oe,
    input wire logic sda3_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ========================================
    // a quiet stretch means no bus is being driven
    sequence idle3_s;
        (!busy)[*3];
    endsequence
    sequence scl3_low_s;
        $rose(scl3_oe) ##1 scl3_oe[*2];
    endsequence
    fuse_locked_a: assert property (!fuse_write_allow) else $error("fuse write allowed");
    bus_sel_a: assert property (bus12_sel == 2'h1 || bus12_sel == 2'h2) else $error("bad bus select");
    shared_hold_a: assert property (scl12_oe |-> $stable(bus12_sel)) else $error("select moved");
    idle12_a: assert property (idle3_s |-> !scl12_oe && !sda12_oe) else $error("bus12 active idle");
    idle3_a: assert property (idle3_s |-> !scl3_oe && !sda3_oe) else $error("bus3 active idle");
    i2c_mode_a: assert property ($rose(sda12_oe || sda3_oe) |-> mode == ACI_FN_I2C) else $error("i2c outside mode");
    boot_mode_a: assert property (boot_start |-> mode == ACI_FN_BOOT ##1 !boot_start) else $error("boot pulse");
    uart_mode_a: assert property (uart_tx_valid |-> mode == ACI_FN_SERIAL) else $error("uart outside serial");
    scl_width_a: assert property ($rose(scl3_oe) |-> scl3_low_s) else $error("scl low too short");
endmodule
bind aci_interp aci_interp_chk #(.QTR_CYC(QTR_CYC)) u_chk (.ref_clk, .rst_n, .rx_data, .rx_valid, .tx_data,
    .tx_valid, .mode, .boot_start, .fuse_write_allow, .uart_tx_data, .uart_tx_valid, .busy, .scl12_in, .sda12_in,
    .scl12_oe, .sda12_oe, .bus12_sel, .scl3_in, .sda3_in, .scl3_oe, .sda3_oe);
`default_nettype wire

// >>> tb/testbench.sv
// testbench: scenario tasks for the command interpreter
// assumes three behavioural slaves on open-drain wires with pull-ups
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
    import aci_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic rx_valid = 1'b0;
    wire logic [7:0] tx_data, uart_tx_data;
    wire logic [2:0] mode;
    wire logic [1:0] bus12_sel;
    wire logic tx_valid, boot_start, fuse_write_allow, uart_tx_valid, busy;
    wire logic scl12_oe, sda12_oe, scl3_oe, sda3_oe, sa_oe, sb_oe, sc_oe;
    wire logic [7:0] sa_addr, sa_last, sa_n, sb_addr, sb_last, sb_n, sc_addr, sc_last, sc_n;
    // ========================================
    // open-drain resolution, pull-up when nobody pulls
    wire logic scl12 = ~scl12_oe;
    wire logic sda12 = ~(sda12_oe | sa_oe | sb_oe);
    wire logic scl3 = ~scl3_oe;
    wire logic sda3 = ~(sda3_oe | sc_oe);
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int tx_cnt = 0;
    int u_cnt = 0;
    int boot_cnt = 0;
    int oe_cnt = 0;
    logic [7:0] tx_last = 8'h00;
    logic [7:0] u_last = 8'h00;
    always #2.5 ref_clk = ~ref_clk;
    aci_interp #(.QTR_CYC(4)) u_aci_interp (.ref_clk(ref_clk), .rst_n(rst_n), .rx_data(rx_data),
        .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .mode(mode), .boot_start(boot_start),
        .fuse_write_allow(fuse_write_allow), .uart_tx_data(uart_tx_data), .uart_tx_valid(uart_tx_valid),
        .busy(busy), .scl12_in(scl12), .sda12_in(sda12), .scl12_oe(scl12_oe), .sda12_oe(sda12_oe),
        .bus12_sel(bus12_sel), .scl3_in(scl3), .sda3_in(sda3), .scl3_oe(scl3_oe), .sda3_oe(sda3_oe));
    aci_i2c_slave #(.ADDR(7'd20)) u_sa (.scl(scl12), .sda(sda12), .sda_oe(sa_oe), .rx_addr(sa_addr),
        .last_byte(sa_last), .nbytes(sa_n));
    aci_i2c_slave #(.ADDR(7'd22)) u_sb (.scl(scl12), .sda(sda12), .sda_oe(sb_oe), .rx_addr(sb_addr),
        .last_byte(sb_last), .nbytes(sb_n));
    aci_i2c_slave #(.ADDR(7'd9), .RD(8'hc3)) u_sc (.scl(scl3), .sda(sda3), .sda_oe(sc_oe), .rx_addr(sc_addr),
        .last_byte(sc_last), .nbytes(sc_n));
    // ========================================
    // output monitors; pulses last one cycle so count them here
    always @(posedge ref_clk) begin
        cyc++;
        if (tx_valid === 1'b1) begin tx_cnt++; tx_last = tx_data; end
        if (uart_tx_valid === 1'b1) begin u_cnt++; u_last = uart_tx_data; end
        if (boot_start === 1'b1) boot_cnt++;
        if ((scl12_oe | sda12_oe | scl3_oe | sda3_oe) !== 1'b0) oe_cnt++;
        if (cyc == 40000) begin bad_count++; wrap_up(); end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one character per strobe with a gap cycle between
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge ref_clk); rx_data <= s[i]; rx_valid <= 1'b1;
            @(posedge ref_clk); rx_valid <= 1'b0;
        end
    endtask
    // bounded wait for the command to finish
    task automatic wait_done();
        int n;
        n = 0;
        repeat (12) @(posedge ref_clk);
        while (busy !== 1'b0 && n < 5000) begin @(posedge ref_clk); n++; end
        `CHK(busy, 1'b0)
        repeat (4) @(posedge ref_clk);
    endtask
    // ========================================
    // scenarios
    task automatic t_write();
        int o;
        o = oe_cnt;
        send("c1 20 w 2 ab");
        repeat (40) @(posedge ref_clk);
        `CHK(oe_cnt, o)
        send("\r");
        wait_done();
        `CHK(sa_addr, {7'd20, 1'b0})
        `CHK(sa_n, 8'h02)
        `CHK(sa_last, 8'h62)
        `CHK(bus12_sel, 2'h1)
    endtask
    task automatic t_hex_space();
        send("C2,\\x16,w,2, z\r");
        wait_done();
        `CHK(sb_addr, {7'h16, 1'b0})
        `CHK(sb_n, 8'h02)
        `CHK(sb_last, 8'h7a)
        `CHK(bus12_sel, 2'h2)
    endtask
    task automatic t_read3();
        int t;
        t = tx_cnt;
        send("c3 9 r 2\r");
        wait_done();
        `CHK(sc_addr, {7'd9, 1'b1})
        `CHK(tx_cnt - t, 2)
        `CHK(tx_last, 8'hc3)
    endtask
    task automatic t_reject();
        int o;
        o = oe_cnt;
        send("c4 20 w 1 a\r");
        send("c1 \\x80 w 1 a\r");
        send("c1 20 w 65\r");
        send("z\r");
        repeat (60) @(posedge ref_clk);
        `CHK(oe_cnt, o)
        send("c1 20 w 64\r");
        repeat (60) @(posedge ref_clk);
        `CHK(busy, 1'b0)
    endtask
    task automatic t_serial_boot();
        int u;
        send("s\r");
        repeat (8) @(posedge ref_clk);
        `CHK(mode, 3'(ACI_FN_SERIAL))
        u = u_cnt;
        send("h");
        repeat (6) @(posedge ref_clk);
        `CHK(u_cnt - u, 1)
        `CHK(u_last, 8'h68)
        send("\\c");
        send("b\r");
        repeat (8) @(posedge ref_clk);
        `CHK(boot_cnt, 1)
        `CHK(mode, 3'(ACI_FN_BOOT))
        send("?\r");
        repeat (8) @(posedge ref_clk);
        `CHK(mode, 3'(ACI_FN_HELP))
        `CHK(fuse_write_allow, 1'b0)
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        // boot pin entry lies with the host; reset alone starts nothing
        @(posedge ref_clk);
        `CHK(boot_cnt, 0)
        t_write();
        t_hex_space();
        t_read3();
        t_reject();
        t_serial_boot();
        wrap_up();
    end
endmodule
`default_nettype wire
